/* hw/watchdog_pkg.sv */
// Purpose: shared constants and types for the watchdog block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   byte offsets are byte addresses on the apb side
package watchdog_pkg;
	localparam logic [15:0] CONTROL_ADDR   = 16'hffae;
	localparam logic [15:0] COUNT_ADDR     = 16'hffb0;
	localparam logic [15:0] IRQ_STAT_ADDR  = 16'hffb4;
	localparam logic [15:0] IRQ_MASK_ADDR  = 16'hffb8;
	localparam logic [15:0] COMMAND_ADDR   = 16'hffbc;
	localparam logic [15:0] ADDR_ALIGN     = 16'hfffc;
	localparam int          DIV_SLOW       = 128;
	localparam int          DIV_FAST       = 2;
	localparam logic [6:0]  DIV_SLOW_LAST  = 7'(DIV_SLOW - 1);
	localparam logic [6:0]  DIV_FAST_MASK  = 7'(DIV_FAST - 1);
	localparam logic [7:0]  CTRL_LOW_HW    = 8'h1c;
	localparam logic [7:0]  CTRL_LOW_SW    = 8'h04;
	localparam logic [7:0]  CTRL_LOW_WDT   = 8'h06;
	localparam logic [7:0]  CTRL_LOW_INIT  = 8'h00;
	localparam int          BIT_DIVSEL     = 0;
	localparam int          BIT_WDT_FLAG   = 1;
	localparam int          BIT_SW_FLAG    = 2;
	localparam int          BIT_SHW_FLAG   = 3;
	localparam int          BIT_LHW_FLAG   = 4;
	localparam int          CMD_SERVICE    = 0;
	localparam int          CMD_SW_RESET   = 1;
	localparam int          CMD_DISABLE    = 2;
	localparam int          CMD_END_OF_INIT_INSTRUCTION      = 3;
	localparam int          IRQ_OVERFLOW   = 0;
	localparam int          IRQ_SERVICE    = 1;
	localparam int          IRQ_W          = 2;
	localparam int          RST_PULSE      = 4;
	localparam logic [2:0]  RST_PULSE_LAST = 3'(RST_PULSE - 1);
	localparam logic [15:0] COUNT_MAX      = 16'hffff;
	localparam logic [15:0] COUNT_ZERO     = 16'h0000;

	typedef struct packed {
		logic [7:0] high_byte_reload;
		logic [7:0] low;
	} control_t;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_RESET = 2'b01,
		ST_OFF   = 2'b10
	} wd_state_t;
endpackage

/* hw/watchdog_timer.sv */
// Purpose: 16-bit watchdog with reload, reset-source flags and reset output
// Assumes: apb slave, zero wait states, sync active-low reset
// Notes:   cpu instructions arrive as write-only command bits over apb
`timescale 1ns/100ps

// Notes on behaviour
// - an overflow before service starts an internal reset sequence.
// - the watchdog reset drives the reset output pin low.
// - the counter is a 16-bit up counter ticked at cpu clock over 2 or 128.
// - two chained 8-bit stages, the high one loaded with the reload value on service.
// - each service clears the low 8 bits of the counter.
// - the count reads through a read-only word and writes to it do nothing.
// - divider select 0 picks clock over 2, 1 picks clock over 128.
// - the watchdog reset flag sets on overflow and clears on service.
// - the software reset flag sets when the software reset command runs.
// - the external reset input sets both long and short hardware flags.
// - control bits 7, 6 and 5 are reserved and always read zero.
// - the control high byte holds the writable reload value.
// - after any reset the watchdog runs from zero at clock over 2.
// - disable works only before the first end-of-init or service.
// - control low byte after reset is 0x1c hardware, 0x04 software, 0x06 watchdog.
module watchdog_timer
	import watchdog_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_external_reset_input,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             o_reset_output_pin_n,
	output logic             o_internal_reset,
	output logic             o_irq
);
	function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
		return (a & ADDR_ALIGN) == (base & ADDR_ALIGN);
	endfunction

	control_t         control_reg;
	logic      [15:0] count_reg;
	logic      [6:0]  prescale_reg;
	wd_state_t        state_reg;
	logic             armed_reg;
	logic      [2:0]  rst_cnt_reg;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic             access;
	logic             wr;
	logic             rd;
	logic             tick;
	logic             service;
	logic             sw_reset;
	logic             wd_reset;
	logic             hw_reset;
	logic             any_reset;
	logic             overflow;
	logic      [IRQ_W-1:0] irq_set;

	assign access   = psel && penable;
	assign wr       = access && pwrite;
	assign rd       = access && !pwrite;
	assign service  = wr && hit(paddr, COMMAND_ADDR) && pwdata[CMD_SERVICE];
	assign sw_reset = wr && hit(paddr, COMMAND_ADDR) && pwdata[CMD_SW_RESET];
	assign hw_reset = !i_external_reset_input;
	// the divided clocks are enables so the counter stays on one clock
	assign tick = control_reg.low[BIT_DIVSEL] ? (prescale_reg == DIV_SLOW_LAST)
		: ((prescale_reg & DIV_FAST_MASK) == DIV_FAST_MASK);
	assign overflow  = (state_reg == ST_RUN) && tick && !service && count_reg == COUNT_MAX;
	assign wd_reset  = (state_reg == ST_RESET) && rst_cnt_reg == RST_PULSE_LAST;
	assign any_reset = hw_reset || sw_reset || wd_reset;
	assign irq_set   = {service, overflow};

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst || any_reset)
			prescale_reg <= '0;
		else
			prescale_reg <= prescale_reg + 7'h01;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst || any_reset)
			count_reg <= COUNT_ZERO;
		else if (service)
			count_reg <= {control_reg.high_byte_reload, 8'h00};
		else if (state_reg == ST_RUN && tick)
			count_reg <= count_reg + 16'h0001;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			state_reg   <= ST_RUN;
			rst_cnt_reg <= '0;
		end else if (hw_reset || sw_reset || wd_reset) begin
			state_reg   <= ST_RUN;
			rst_cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_RUN: begin
					if (overflow)
						state_reg <= ST_RESET;
					else if (wr && hit(paddr, COMMAND_ADDR) && pwdata[CMD_DISABLE] && armed_reg)
						state_reg <= ST_OFF;
				end
				ST_RESET: rst_cnt_reg <= rst_cnt_reg + 3'h1;
				ST_OFF: state_reg <= ST_OFF;
				default: state_reg <= ST_RUN;
			endcase
		end
	end

	// disable is only honoured in the window after reset
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst || any_reset)
			armed_reg <= 1'b1;
		else if (service || (wr && hit(paddr, COMMAND_ADDR) && pwdata[CMD_END_OF_INIT_INSTRUCTION]))
			armed_reg <= 1'b0;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			control_reg <= '{high_byte_reload: 8'h00, low: CTRL_LOW_INIT};
		end else if (hw_reset) begin
			control_reg <= '{high_byte_reload: 8'h00, low: CTRL_LOW_HW};
		end else if (wd_reset) begin
			control_reg.low <= CTRL_LOW_WDT;
		end else if (sw_reset) begin
			control_reg.low <= CTRL_LOW_SW;
		end else begin
			if (wr && hit(paddr, CONTROL_ADDR)) begin
				control_reg.high_byte_reload   <= pwdata[15:8];
				control_reg.low[BIT_DIVSEL]    <= pwdata[BIT_DIVSEL];
			end
			if (wr && hit(paddr, COMMAND_ADDR) && pwdata[CMD_END_OF_INIT_INSTRUCTION])
				control_reg.low[BIT_LHW_FLAG:BIT_WDT_FLAG] <= 4'h0;
			if (overflow)
				control_reg.low[BIT_WDT_FLAG] <= 1'b1;
			else if (service)
				control_reg.low[BIT_WDT_FLAG] <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			o_reset_output_pin_n <= 1'b1;
			o_internal_reset     <= 1'b0;
		end else begin
			o_reset_output_pin_n <= !(state_reg == ST_RESET || overflow);
			o_internal_reset     <= (state_reg == ST_RESET || overflow);
		end
	end

	// a read clears the status, but a new event in that cycle still wins
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			if (rd && hit(paddr, IRQ_STAT_ADDR))
				irq_stat_reg <= irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
			if (wr && hit(paddr, IRQ_MASK_ADDR))
				irq_mask_reg <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst)
			o_irq <= 1'b0;
		else
			o_irq <= |(((rd && hit(paddr, IRQ_STAT_ADDR)) ? irq_set : (irq_stat_reg | irq_set))
				& irq_mask_reg);
	end

	// count and control reads are registered; zero wait states on every access
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (psel && !penable) begin
				if (hit(paddr, CONTROL_ADDR))
					prdata <= {16'h0000, control_reg.high_byte_reload, 3'b000,
						control_reg.low[4:0]};
				else if (hit(paddr, COUNT_ADDR))
					prdata <= {16'h0000, count_reg};
				else if (hit(paddr, IRQ_STAT_ADDR))
					prdata <= {{(32-IRQ_W){1'b0}}, irq_stat_reg | irq_set};
				else if (hit(paddr, IRQ_MASK_ADDR))
					prdata <= {{(32-IRQ_W){1'b0}}, irq_mask_reg};
				else if (!hit(paddr, COMMAND_ADDR))
					pslverr <= 1'b1;
			end
		end
	end

	// an outside reset during the sequence aborts it, so that case is not checked
	a_wrap_resets: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || hw_reset || sw_reset)
		overflow |=> state_reg == ST_RESET ##3 wd_reset)
		else $error("overflow did not lead to reset");
	a_pin_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		overflow |=> !o_reset_output_pin_n)
		else $error("reset pin not low after overflow");
	a_service_load: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || any_reset)
		service |=> count_reg == {$past(control_reg.high_byte_reload), 8'h00})
		else $error("service load wrong");
	a_count_step: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || any_reset)
		(state_reg == ST_RUN && tick && !service) |=> count_reg == $past(count_reg) + 16'h0001)
		else $error("count did not advance");
	a_flag_set: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		overflow && !hw_reset && !sw_reset |=> control_reg.low[BIT_WDT_FLAG])
		else $error("watchdog flag not set");
	a_sw_value: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		sw_reset && !hw_reset && !wd_reset |=> control_reg.low == CTRL_LOW_SW && count_reg == COUNT_ZERO)
		else $error("software reset value wrong");
	a_hw_value: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		hw_reset |=> control_reg.low == CTRL_LOW_HW)
		else $error("hardware reset value wrong");
	a_disable_late: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(!armed_reg && state_reg == ST_RUN && !overflow) |=> state_reg != ST_OFF)
		else $error("late disable honoured");
	a_fast_tick: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || any_reset)
		((!control_reg.low[BIT_DIVSEL] && tick) ##1 !control_reg.low[BIT_DIVSEL]
			##1 !control_reg.low[BIT_DIVSEL]) |-> tick && !$past(tick))
		else $error("divide by two tick spacing wrong");

	a_low_clear: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || any_reset)
		service |=> count_reg[7:0] == 8'h00)
		else $error("service left low byte set");

	// a write to the count word must leave it alone apart from a normal tick
	a_count_ro: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || any_reset)
		(wr && hit(paddr, COUNT_ADDR) && !(state_reg == ST_RUN && tick))
			|=> count_reg == $past(count_reg))
		else $error("count changed by a write");

	a_slow_tick: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || any_reset)
		(control_reg.low[BIT_DIVSEL] && tick) |=> prescale_reg == 7'h00)
		else $error("divide by 128 tick misplaced");

	a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		control_reg.low[7:5] == 3'b000)
		else $error("reserved control bits set");

	a_irq_level: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		1'b1 |=> o_irq == |(irq_stat_reg & $past(irq_mask_reg)))
		else $error("interrupt level wrong");

	a_reset_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || hw_reset)
		$fell(o_reset_output_pin_n) |=> !o_reset_output_pin_n [*4] ##1 o_reset_output_pin_n)
		else $error("reset pin pulse length wrong");

	a_ready_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		pready |=> !pready)
		else $error("ready held too long");
endmodule

/* bench/cpu_core_model.sv */
// Purpose: cpu core side, issuing instructions and register accesses over apb
// Assumes: called right after a rising edge of i_sys_clk
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/100ps
module cpu_core_model (
	input  wire logic        i_sys_clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [15:0] paddr,
	output logic      [31:0] pwdata
);
	int hangs = 0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
	end
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			hangs++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		// one idle edge so no signal is driven twice in one step
		@(posedge i_sys_clk);
	endtask
endmodule

/* bench/watchdog_timer_16bit_test.sv */
// Purpose: self-checking bench for the watchdog timer
// Assumes: zero-wait apb slave, commands as apb writes
// Notes:   expectations come from the reset-source and reload rules
`timescale 1ns/100ps
module watchdog_timer_16bit_test;
	import watchdog_pkg::*;
	logic        i_sys_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic        ext_n = 1'b1;
	logic [31:0] prdata, pwdata, rd, c1;
	logic [15:0] paddr;
	logic        psel, penable, pwrite, pready, pslverr, pin_n, irst, irq, er;
	int          n_errors = 0;
	int          n_tests = 0;
	int          n;
	always #5 i_sys_clk = ~i_sys_clk;
	watchdog_timer i_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
		.i_external_reset_input(ext_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .o_reset_output_pin_n(pin_n), .o_internal_reset(irst),
		.o_irq(irq));
	cpu_core_model i_cpu (.i_sys_clk(i_sys_clk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	task automatic wrap_up();
		$display("errors %0d tests %0d", n_errors + i_cpu.hangs, n_tests);
		if (n_errors + i_cpu.hangs == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		i_cpu.xfer(w, a, d, rd, er);
		if (i_cpu.hangs != 0)
			wrap_up();
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic cmd(input int b);
		acc(1'b1, COMMAND_ADDR, 32'h1 << b);
	endtask
	// count change over exactly 20 cycles between two sampled reads
	task automatic delta(input logic [31:0] exp);
		acc(1'b0, COUNT_ADDR, 32'h0);
		c1 = rd;
		repeat (17) @(posedge i_sys_clk);
		acc(1'b0, COUNT_ADDR, 32'h0);
		chk(rd - c1, exp);
	endtask
	task automatic wait_pin(input logic lvl);
		n = 0;
		while (pin_n !== lvl && n < 1000) begin
			@(posedge i_sys_clk);
			n++;
		end
		if (n >= 1000) begin
			n_errors++;
			wrap_up();
		end
	endtask
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		@(posedge i_sys_clk);
		rd_chk(CONTROL_ADDR, 32'h0);
		delta(32'd10);
		acc(1'b1, CONTROL_ADDR, 32'h12ff);
		rd_chk(CONTROL_ADDR, 32'h1201);
		acc(1'b1, IRQ_MASK_ADDR, 32'h2);
		cmd(CMD_SERVICE);
		acc(1'b0, COUNT_ADDR, 32'h0);
		chk({rd[31:1], 1'b0}, 32'h1200);
		chk({31'h0, irq}, 32'h1);
		rd_chk(IRQ_STAT_ADDR, 32'h2);
		chk({31'h0, irq}, 32'h0);
		acc(1'b1, COUNT_ADDR, 32'h0);
		acc(1'b0, COUNT_ADDR, 32'h0);
		chk({rd[31:8], 8'h0}, 32'h1200);
		acc(1'b0, 16'hff00, 32'h0);
		chk({31'h0, er}, 32'h1);
		// fast input, so the overflow comes well inside the pin wait bound
		acc(1'b1, CONTROL_ADDR, 32'hff00);
		cmd(CMD_SERVICE);
		acc(1'b0, COUNT_ADDR, 32'h0);
		chk({rd[31:1], 1'b0}, 32'hff00);
		wait_pin(1'b0);
		chk({31'h0, irst}, 32'h1);
		wait_pin(1'b1);
		@(posedge i_sys_clk);
		rd_chk(CONTROL_ADDR, 32'hff06);
		cmd(CMD_SERVICE);
		rd_chk(CONTROL_ADDR, 32'hff04);
		cmd(CMD_END_OF_INIT_INSTRUCTION);
		cmd(CMD_SW_RESET);
		repeat (2) @(posedge i_sys_clk);
		rd_chk(CONTROL_ADDR, 32'hff04);
		ext_n <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		ext_n <= 1'b1;
		@(posedge i_sys_clk);
		rd_chk(CONTROL_ADDR, 32'h001c);
		cmd(CMD_DISABLE);
		delta(32'd0);
		wrap_up();
	end
endmodule
